// ===== design/gsaux_pkg.sv
// constants, enumerations and timing figures of the genset auxiliary sequencer
// assumes one 10 MHz clock; timers count seconds, exercise durations count minutes
package gsaux_pkg;
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned SECOND_MS = 1000;
  localparam int unsigned CYCLES_PER_SECOND = (SECOND_MS * (CLOCK_HZ / 1000));
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_HALF_CYCLES = (BLINK_HALF_MS * (CLOCK_HZ / 1000));
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int unsigned NUM_LIMIT_SETS = 3;
  localparam int unsigned NUM_EXERCISERS = 7;
  localparam int unsigned SCHED_SLOTS = 144;
  localparam int unsigned HOURS_PER_DAY = 24;
  localparam logic [7:0] HEATER_HYST = 8'h04;
  localparam logic [2:0] PHASE_MASK_SINGLE = 3'h1;
  localparam logic [2:0] PHASE_MASK_ALL = 3'h7;
  localparam logic [1:0] LIMIT_SET_FIRST = 2'h0;
  localparam logic [1:0] LIMIT_SET_SECOND = 2'h1;
  localparam logic [1:0] LIMIT_SET_THIRD = 2'h2;

  // digital input functions
  typedef enum logic [3:0] {
    FN_NONE, FN_SECOND_LIMIT_SET_SELECT, FN_THIRD_LIMIT_SET_SELECT, FN_FORCE_STOP, FN_FORCE_AUTO,
    FN_FORCE_TEST, FN_DISABLE_AUTO_START, FN_FORCE_START, FN_FAULT_RESET, FN_ALARM_MUTE,
    FN_PANEL_LOCK, FN_COUNT
  } gsaux_infunc_e;

  // relay functions
  typedef enum logic [1:0] {RLY_NONE, RLY_BLOCK_HEATER, RLY_FUEL_PUMP, RLY_IDLE} gsaux_relay_e;

  typedef enum logic [1:0] {MODE_STOP, MODE_AUTO, MODE_RUN, MODE_TEST} gsaux_mode_e;

  typedef enum logic [1:0] {WU_IDLE, WU_TIMER, WU_TEMP, WU_DONE} gsaux_wu_e;
endpackage : gsaux_pkg

// ===== design/gsaux_bit_mem.sv
// small synchronous memory holding the weekly permission bits
// one write and one registered read port
`timescale 1ns/1ps
module gsaux_bit_mem #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 144,
  parameter int unsigned AW = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("gsaux_bit_mem: address too narrow for depth");
  end

  // no reset: contents are programmed
  always_ff @(posedge i_clock)
  begin
    if (i_wr_en && (32'(i_wr_addr) < DEPTH))
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // out-of-range slots read as all ones, i.e. operation permitted
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rd_data <= '0;
    end
    else if (32'(i_rd_addr) < DEPTH)
    begin
      o_rd_data <= mem[i_rd_addr];
    end
    else
    begin
      o_rd_data <= '1;
    end
  end
endmodule : gsaux_bit_mem

// ===== design/gsaux_sequencer.sv
// genset auxiliary sequencer: limit sets, phase restriction, external modes,
// exercisers, weekly scheduler, warm-up, idle, block heater and fuel pump
// assumes synchronous inputs and digitised analog values
`timescale 1ns/1ps

// Overview of operation
// (RULE1) three limit sets chosen by select inputs
// (RULE2) single phase mode checks phase one only
// (RULE3) any input can take any control function
// (RULE4) external mode overrides keys, keys remembered
// (RULE5) seven exercisers: day, hour, duration, load
// (RULE6) exercise start runs engine, load if on-load
// (RULE7) off-load exercise transfers only with backup
// (RULE8) exercise end restores previous mode
// (RULE9) any mode key ends exercise at once
// (RULE10) scheduler only in auto, flashes auto led
// (RULE11) 144 hourly permission bits gate auto running
// (RULE12) method 0: warm-up timer then load
// (RULE13) method 1: timer then temperature, skip if warm
// (RULE14) idle output for idle timer, start and cool-down
// (RULE15) idle suppresses low speed and voltage protection
// (RULE16) heater on at limit minus 4, off above
// (RULE17) pump on below low, off at high
// (RULE18) pump off when filling timer expires
// (RULE19) heater, pump, idle routable to any relay
// (RULE20) both selects active picks the third set
// (RULE21) fill timeout latches pump off until reset
module gsaux_sequencer #(
  parameter int unsigned NUM_INPUTS = 8,
  parameter int unsigned NUM_RELAYS = 8,
  parameter int unsigned CYCLES_PER_SECOND = gsaux_pkg::CYCLES_PER_SECOND,
  parameter int unsigned BLINK_HALF_CYCLES = gsaux_pkg::BLINK_HALF_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [NUM_INPUTS-1:0] i_din,
  input wire gsaux_pkg::gsaux_infunc_e [NUM_INPUTS-1:0] i_input_func,
  input wire logic i_key_stop,
  input wire logic i_key_auto,
  input wire logic i_key_run,
  input wire logic i_key_test,
  input wire logic i_single_phase,
  input wire logic [2:0] i_gen_volt_fault,
  input wire logic [2:0] i_gen_over_current,
  input wire logic [2:0] i_mains_volt_fault,
  input wire logic i_mains_fail,
  input wire logic i_emergency_backup,
  input wire logic [gsaux_pkg::NUM_EXERCISERS-1:0] i_ex_enable,
  input wire logic [gsaux_pkg::NUM_EXERCISERS-1:0] i_ex_monthly,
  input wire logic [gsaux_pkg::NUM_EXERCISERS-1:0] i_ex_on_load,
  input wire logic [gsaux_pkg::NUM_EXERCISERS-1:0][4:0] i_ex_day,
  input wire logic [gsaux_pkg::NUM_EXERCISERS-1:0][4:0] i_ex_hour,
  input wire logic [gsaux_pkg::NUM_EXERCISERS-1:0][15:0] i_ex_duration_min,
  input wire logic [2:0] i_rtc_dow,
  input wire logic [4:0] i_rtc_dom,
  input wire logic [4:0] i_rtc_hour,
  input wire logic i_sched_wr_en,
  input wire logic [7:0] i_sched_wr_slot,
  input wire logic i_sched_wr_permit,
  input wire logic i_engine_running,
  input wire logic i_cooldown,
  input wire logic i_warmup_method,
  input wire logic [15:0] i_warmup_time_s,
  input wire logic [15:0] i_idle_time_s,
  input wire logic [7:0] i_coolant_temp,
  input wire logic [7:0] i_warmup_temp_limit,
  input wire logic [7:0] i_fuel_level,
  input wire logic [7:0] i_pump_low_limit,
  input wire logic [7:0] i_pump_high_limit,
  input wire logic [15:0] i_fill_time_s,
  input wire gsaux_pkg::gsaux_relay_e [NUM_RELAYS-1:0] i_relay_func,
  output gsaux_pkg::gsaux_mode_e o_mode,
  output logic [1:0] o_limit_set,
  output logic [2:0] o_phase_mask,
  output logic o_gen_volt_alarm,
  output logic o_gen_oc_alarm,
  output logic o_mains_volt_alarm,
  output logic o_disable_auto_start,
  output logic o_fault_reset,
  output logic o_alarm_mute,
  output logic o_panel_lock,
  output logic o_exercise_active,
  output logic o_engine_run_req,
  output logic o_gen_load_req,
  output logic o_auto_led,
  output logic o_warmup_done,
  output logic o_idle,
  output logic o_low_speed_prot_en,
  output logic o_low_volt_prot_en,
  output logic o_block_heater,
  output logic o_fuel_pump,
  output logic o_fill_timeout,
  output logic [NUM_RELAYS-1:0] o_relay
);
  import gsaux_pkg::*;

  if (NUM_INPUTS < 1 || NUM_RELAYS < 1 || CYCLES_PER_SECOND < 2 || BLINK_HALF_CYCLES < 1) begin : g_bad
    $error("gsaux_sequencer: unsupported parameter values");
  end

  typedef struct packed {
    logic [31:0] presc;
    logic sec_tick;
    logic [5:0] sec_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    gsaux_mode_e key_mode;
    gsaux_mode_e mode;
    logic ex_active;
    logic ex_on_load;
    logic [15:0] ex_min_left;
    logic [4:0] prev_hour;
    gsaux_wu_e wu;
    logic [15:0] wu_cnt;
    logic run_prev;
    logic cool_prev;
    logic [15:0] idle_cnt;
    logic idle;
    logic heater;
    logic pump;
    logic [15:0] pump_cnt;
    logic pump_timeout;
    logic [1:0] limit_set;
    logic [2:0] phase_mask;
    logic gen_volt_alarm;
    logic gen_oc_alarm;
    logic mains_volt_alarm;
    logic [3:0] ctl;
    logic run_req;
    logic load_req;
    logic auto_led;
    logic [NUM_RELAYS-1:0] relay;
  } gsaux_state_s;

  gsaux_state_s q;
  gsaux_state_s d;
  logic [FN_COUNT-1:0] fact;
  logic sched_permit;

  function automatic logic [7:0] slot_of(input logic [2:0] dow, input logic [4:0] hour);
    slot_of = 8'(dow * HOURS_PER_DAY + hour);
  endfunction : slot_of

  function automatic logic [15:0] dec_sat(input logic [15:0] v);
    dec_sat = (v == 16'h0000) ? 16'h0000 : 16'(v - 16'h0001);
  endfunction : dec_sat

  gsaux_bit_mem #(.WIDTH(1), .DEPTH(SCHED_SLOTS), .AW(8)) u_sched ( // [RULE11]
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_wr_en(i_sched_wr_en),
    .i_wr_addr(i_sched_wr_slot),
    .i_wr_data(i_sched_wr_permit),
    .i_rd_addr(slot_of(i_rtc_dow, i_rtc_hour)),
    .o_rd_data(sched_permit)
  );

  always_comb
  begin
    logic key_any;
    logic ext_forced;
    logic minute_tick;
    logic sched_block;
    gsaux_mode_e ext_mode;
    gsaux_mode_e key_mode_new;
    key_any = 1'b0;
    ext_forced = 1'b0;
    minute_tick = 1'b0;
    sched_block = 1'b0;
    ext_mode = MODE_STOP;
    key_mode_new = MODE_STOP;
    d = q;
    fact = '0;
    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      if (i_input_func[i] != FN_NONE && i_input_func[i] < FN_COUNT)
      begin
        fact[i_input_func[i]] = fact[i_input_func[i]] | i_din[i]; // [RULE3]
      end
    end

    // time base
    d.sec_tick = (q.presc == 32'(CYCLES_PER_SECOND - 1));
    d.presc = d.sec_tick ? 32'h0 : 32'(q.presc + 32'h1);
    minute_tick = q.sec_tick && (q.sec_cnt == 6'(SEC_PER_MIN - 1));
    if (q.sec_tick)
    begin
      d.sec_cnt = minute_tick ? 6'h00 : 6'(q.sec_cnt + 6'h01);
    end
    d.blink_cnt = (q.blink_cnt == 32'(BLINK_HALF_CYCLES - 1)) ? 32'h0 : 32'(q.blink_cnt + 32'h1);
    d.blink = (q.blink_cnt == 32'(BLINK_HALF_CYCLES - 1)) ? !q.blink : q.blink;

    // limit set, third wins over second
    if (fact[FN_THIRD_LIMIT_SET_SELECT])
    begin
      d.limit_set = LIMIT_SET_THIRD; // [RULE1] [RULE20]
    end
    else if (fact[FN_SECOND_LIMIT_SET_SELECT])
    begin
      d.limit_set = LIMIT_SET_SECOND; // [RULE1]
    end
    else
    begin
      d.limit_set = LIMIT_SET_FIRST;
    end

    d.phase_mask = i_single_phase ? PHASE_MASK_SINGLE : PHASE_MASK_ALL; // [RULE2]
    d.gen_volt_alarm = |(i_gen_volt_fault & d.phase_mask); // [RULE2]
    d.gen_oc_alarm = |(i_gen_over_current & d.phase_mask); // [RULE2]
    d.mains_volt_alarm = |(i_mains_volt_fault & d.phase_mask); // [RULE2]
    d.ctl = {fact[FN_DISABLE_AUTO_START], fact[FN_FAULT_RESET], fact[FN_ALARM_MUTE], fact[FN_PANEL_LOCK]}; // [RULE3]

    // forced modes, stop first
    if (fact[FN_FORCE_STOP])
    begin
      ext_forced = 1'b1;
      ext_mode = MODE_STOP;
    end
    else if (fact[FN_FORCE_AUTO])
    begin
      ext_forced = 1'b1;
      ext_mode = MODE_AUTO;
    end
    else if (fact[FN_FORCE_TEST])
    begin
      ext_forced = 1'b1;
      ext_mode = MODE_TEST;
    end

    // keys ignored while forced or locked
    key_any = (i_key_stop || i_key_auto || i_key_run || i_key_test) && !ext_forced && !fact[FN_PANEL_LOCK]; // [RULE4]
    if (i_key_stop)
    begin
      key_mode_new = MODE_STOP;
    end
    else if (i_key_auto)
    begin
      key_mode_new = MODE_AUTO;
    end
    else if (i_key_run)
    begin
      key_mode_new = MODE_RUN;
    end
    else
    begin
      key_mode_new = MODE_TEST;
    end
    if (key_any)
    begin
      d.key_mode = key_mode_new; // [RULE4]
      d.ex_active = 1'b0; // [RULE9]
    end

    // exercise starts on an hour change; lowest entry wins
    d.prev_hour = i_rtc_hour;
    if (q.ex_active && !key_any && minute_tick)
    begin
      d.ex_min_left = dec_sat(q.ex_min_left);
      if (q.ex_min_left <= 16'h0001)
      begin
        d.ex_active = 1'b0; // [RULE8]
      end
    end
    if (!q.ex_active && !key_any && (i_rtc_hour != q.prev_hour))
    begin
      for (int e = NUM_EXERCISERS - 1; e >= 0; e--)
      begin
        if (i_ex_enable[e] && i_ex_hour[e] == i_rtc_hour && i_ex_duration_min[e] != 16'h0000 &&
            (i_ex_monthly[e] ? (i_ex_day[e] == i_rtc_dom) : (i_ex_day[e] == {2'b00, i_rtc_dow})))
        begin
          d.ex_active = 1'b1; // [RULE5]
          d.ex_on_load = i_ex_on_load[e];
          d.ex_min_left = i_ex_duration_min[e];
        end
      end
    end

    // key mode kept under the exercise, restored at its end
    if (ext_forced)
    begin
      d.mode = ext_mode; // [RULE4]
    end
    else if (d.ex_active)
    begin
      d.mode = d.ex_on_load ? MODE_TEST : MODE_RUN; // [RULE6]
    end
    else
    begin
      d.mode = d.key_mode; // [RULE8]
    end

    sched_block = (d.mode == MODE_AUTO) && !sched_permit; // [RULE10] [RULE11]
    d.auto_led = (d.mode == MODE_AUTO) && (!sched_block || q.blink); // [RULE10]

    // warm-up sequence
    d.run_prev = i_engine_running;
    case (q.wu)
      WU_IDLE:
      begin
        if (i_engine_running)
        begin
          if (i_warmup_method && i_coolant_temp >= i_warmup_temp_limit)
          begin
            d.wu = WU_DONE; // [RULE13]
          end
          else
          begin
            d.wu = WU_TIMER;
            d.wu_cnt = i_warmup_time_s;
          end
        end
      end
      WU_TIMER:
      begin
        if (q.wu_cnt == 16'h0000)
        begin
          d.wu = i_warmup_method ? WU_TEMP : WU_DONE; // [RULE12] [RULE13]
        end
        else if (q.sec_tick)
        begin
          d.wu_cnt = dec_sat(q.wu_cnt);
        end
      end
      WU_TEMP:
      begin
        if (i_coolant_temp >= i_warmup_temp_limit)
        begin
          d.wu = WU_DONE; // [RULE13]
        end
      end
      WU_DONE:
      begin
        d.wu = WU_DONE;
      end
      default:
      begin
        d.wu = WU_IDLE;
      end
    endcase
    if (!i_engine_running)
    begin
      d.wu = WU_IDLE;
    end

    d.run_req = (d.mode == MODE_RUN) || (d.mode == MODE_TEST) ||
                ((d.mode == MODE_AUTO) && !sched_block &&
                 ((i_mains_fail && !fact[FN_DISABLE_AUTO_START]) || fact[FN_FORCE_START])); // [RULE6] [RULE10]
    d.load_req = (q.wu == WU_DONE) && i_engine_running &&
                 ((d.mode == MODE_TEST) || // [RULE6] [RULE12]
                  ((d.mode == MODE_AUTO) && !sched_block && i_mains_fail && !fact[FN_DISABLE_AUTO_START]) ||
                  (d.ex_active && !d.ex_on_load && i_mains_fail && i_emergency_backup)); // [RULE7]

    // idle reloads at engine start and cool-down
    d.cool_prev = i_cooldown;
    if ((i_engine_running && !q.run_prev) || (i_cooldown && !q.cool_prev))
    begin
      d.idle_cnt = i_idle_time_s; // [RULE14]
    end
    else if (q.sec_tick)
    begin
      d.idle_cnt = dec_sat(q.idle_cnt);
    end
    d.idle = (d.idle_cnt != 16'h0000); // [RULE14]

    // 9-bit sum cannot wrap
    if ({1'b0, i_coolant_temp} + {1'b0, HEATER_HYST} <= {1'b0, i_warmup_temp_limit})
    begin
      d.heater = 1'b1; // [RULE16]
    end
    else if (i_coolant_temp > i_warmup_temp_limit)
    begin
      d.heater = 1'b0; // [RULE16]
    end

    // clear before set, so a timeout wins
    if (fact[FN_FAULT_RESET])
    begin
      d.pump_timeout = 1'b0; // [RULE21]
    end
    if (q.pump)
    begin
      if (i_fuel_level >= i_pump_high_limit)
      begin
        d.pump = 1'b0; // [RULE17]
      end
      else if (q.sec_tick)
      begin
        if (16'(q.pump_cnt + 16'h0001) >= i_fill_time_s)
        begin
          d.pump = 1'b0; // [RULE18]
          d.pump_timeout = 1'b1; // [RULE21]
        end
        else
        begin
          d.pump_cnt = 16'(q.pump_cnt + 16'h0001);
        end
      end
    end
    else if (!d.pump_timeout && i_fuel_level < i_pump_low_limit)
    begin
      d.pump = 1'b1; // [RULE17]
      d.pump_cnt = 16'h0000;
    end

    for (int r = 0; r < NUM_RELAYS; r++)
    begin
      case (i_relay_func[r])
        RLY_BLOCK_HEATER: d.relay[r] = d.heater; // [RULE19]
        RLY_FUEL_PUMP: d.relay[r] = d.pump; // [RULE19]
        RLY_IDLE: d.relay[r] = d.idle; // [RULE19]
        default: d.relay[r] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      q <= '{wu: WU_IDLE, key_mode: MODE_STOP, mode: MODE_STOP, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign o_mode = q.mode;
  assign o_limit_set = q.limit_set;
  assign o_phase_mask = q.phase_mask;
  assign o_gen_volt_alarm = q.gen_volt_alarm;
  assign o_gen_oc_alarm = q.gen_oc_alarm;
  assign o_mains_volt_alarm = q.mains_volt_alarm;
  assign {o_disable_auto_start, o_fault_reset, o_alarm_mute, o_panel_lock} = q.ctl;
  assign o_exercise_active = q.ex_active;
  assign o_engine_run_req = q.run_req;
  assign o_gen_load_req = q.load_req;
  assign o_auto_led = q.auto_led;
  assign o_warmup_done = (q.wu == WU_DONE);
  assign o_idle = q.idle;
  assign o_low_speed_prot_en = !q.idle; // [RULE15]
  assign o_low_volt_prot_en = !q.idle; // [RULE15]
  assign o_block_heater = q.heater;
  assign o_fuel_pump = q.pump;
  assign o_fill_timeout = q.pump_timeout;
  assign o_relay = q.relay;

  AST_THIRD_WINS: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE20]
    fact[FN_THIRD_LIMIT_SET_SELECT] |=> (o_limit_set == LIMIT_SET_THIRD))
    else $error("third limit set not applied");
  AST_SINGLE_PHASE: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE2]
    (i_single_phase && !i_gen_volt_fault[0]) |=> !o_gen_volt_alarm)
    else $error("alarm from phase two or three");
  AST_FORCE_STOP: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE4]
    fact[FN_FORCE_STOP] |=> (o_mode == MODE_STOP))
    else $error("stop not forced");
  AST_KEY_ENDS_EX: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE9]
    (o_exercise_active && i_key_run && !fact[FN_PANEL_LOCK] && !fact[FN_FORCE_STOP] && !fact[FN_FORCE_AUTO]
     && !fact[FN_FORCE_TEST]) |=> (!o_exercise_active && o_mode == MODE_RUN))
    else $error("mode key did not end exercise");
  AST_IDLE_PROT: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE15]
    o_idle |-> (!o_low_speed_prot_en && !o_low_volt_prot_en))
    else $error("protection active during idle");
  AST_HEATER_OFF: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE16]
    (i_coolant_temp > i_warmup_temp_limit) |=> !o_block_heater)
    else $error("heater on above limit");
  AST_PUMP_FULL: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE17]
    (o_fuel_pump && i_fuel_level >= i_pump_high_limit) |=> !o_fuel_pump)
    else $error("pump not stopped at high limit");
  AST_TIMEOUT_HOLDS: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE21]
    (o_fill_timeout && !fact[FN_FAULT_RESET]) |=> (o_fill_timeout && !o_fuel_pump))
    else $error("timeout released early");
  AST_LOAD_AFTER_WARMUP: assert property (@(posedge i_clock) disable iff (i_rst) // [RULE12]
    $rose(o_gen_load_req) |-> $past(q.wu == WU_DONE))
    else $error("load before warm-up");
endmodule : gsaux_sequencer

// ===== sim/gsaux_engine_model.sv
// engine model: answers the run request with a running level
// assumes a registered run request; slow or prompt start
`timescale 1ns/1ps
module gsaux_engine_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_run_req,
  input wire logic i_slow,
  output logic o_running
);
  logic [3:0] wait_q;

  // stops at once when the request drops
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      {wait_q, o_running} <= 5'h00;
    end
    else if (!i_run_req)
    begin
      {wait_q, o_running} <= 5'h00;
    end
    else if (wait_q == (i_slow ? 4'hC : 4'h2))
    begin
      o_running <= 1'b1;
    end
    else
    begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : gsaux_engine_model

// ===== sim/gsaux_sequencer_bench.sv
// self-checking bench for the genset auxiliary sequencer
// assumes 20 cycles a second and a blink half period of 4 cycles
`timescale 1ns/1ps
module gsaux_sequencer_bench;
  import gsaux_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  int fail_count = 0;
  int n_tests = 0;
  logic [3:0] din = 4'h0;
  logic [3:0] keys = 4'h0;
  gsaux_infunc_e [3:0] ifn = {FN_FORCE_START, FN_THIRD_LIMIT_SET_SELECT, FN_SECOND_LIMIT_SET_SELECT, FN_FORCE_STOP};
  gsaux_relay_e [3:0] rfn = {RLY_IDLE, RLY_FUEL_PUMP, RLY_BLOCK_HEATER, RLY_NONE};
  logic sp = 1'b0, mf = 1'b0, eb = 1'b0, cool = 1'b0, wum = 1'b0, slow = 1'b0, swe = 1'b0, swp = 1'b1;
  logic [2:0] gvf = 3'h0, goc = 3'h0, mvf = 3'h0, dow = 3'h0;
  logic [6:0] exen = 7'h18, exmo = 7'h10, exld = 7'h10;
  logic [6:0][4:0] exday = {10'h000, 5'h09, 5'h02, 15'h0000};
  logic [6:0][4:0] exhr = {10'h000, 5'h06, 5'h05, 15'h0000};
  logic [6:0][15:0] exdur = {32'h0, 16'h0001, 16'h0001, 48'h0};
  logic [4:0] dom = 5'h00, hr = 5'h00;
  logic [7:0] sws = 8'h00, temp = 8'h64, tlim = 8'h50, lvl = 8'h64, plo = 8'h14, phi = 8'hC8;
  logic [15:0] wut = 16'h0001, idt = 16'h0002, fill = 16'h0003;
  gsaux_mode_e mode;
  logic [1:0] lset, led;
  logic [2:0] pmask;
  logic [3:0] rly;
  logic gva, goa, mva, das, frs, amt, plk, exa, rreq, lreq, aled, wud, idl, lsp, lvp, htr, pmp, fto, run;
  gsaux_infunc_e ftab [7] = '{FN_FORCE_STOP, FN_FORCE_AUTO, FN_FORCE_TEST, FN_DISABLE_AUTO_START, FN_FAULT_RESET,
    FN_ALARM_MUTE, FN_PANEL_LOCK};
  gsaux_mode_e mtab [7] = '{MODE_STOP, MODE_AUTO, MODE_TEST, MODE_RUN, MODE_RUN, MODE_RUN, MODE_RUN};
  logic [3:0] otab [7] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
  logic [1:0] ltab [4] = '{LIMIT_SET_FIRST, LIMIT_SET_SECOND, LIMIT_SET_THIRD, LIMIT_SET_THIRD};
  logic [7:0] htab [5] = '{8'h4D, 8'h4C, 8'h50, 8'h51, 8'h4D};
  logic [7:0] ptab [5] = '{8'h64, 8'h13, 8'h96, 8'hC8, 8'h13};

  gsaux_sequencer #(.NUM_INPUTS(4), .NUM_RELAYS(4), .CYCLES_PER_SECOND(20), .BLINK_HALF_CYCLES(4)) dut_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_din(din), .i_input_func(ifn), .i_key_stop(keys[0]), .i_key_auto(keys[1]),
    .i_key_run(keys[2]), .i_key_test(keys[3]), .i_single_phase(sp), .i_gen_volt_fault(gvf),
    .i_gen_over_current(goc), .i_mains_volt_fault(mvf), .i_mains_fail(mf), .i_emergency_backup(eb),
    .i_ex_enable(exen), .i_ex_monthly(exmo), .i_ex_on_load(exld), .i_ex_day(exday), .i_ex_hour(exhr),
    .i_ex_duration_min(exdur), .i_rtc_dow(dow), .i_rtc_dom(dom), .i_rtc_hour(hr), .i_sched_wr_en(swe),
    .i_sched_wr_slot(sws), .i_sched_wr_permit(swp), .i_engine_running(run), .i_cooldown(cool),
    .i_warmup_method(wum), .i_warmup_time_s(wut), .i_idle_time_s(idt), .i_coolant_temp(temp),
    .i_warmup_temp_limit(tlim), .i_fuel_level(lvl), .i_pump_low_limit(plo), .i_pump_high_limit(phi),
    .i_fill_time_s(fill), .i_relay_func(rfn), .o_mode(mode), .o_limit_set(lset), .o_phase_mask(pmask),
    .o_gen_volt_alarm(gva), .o_gen_oc_alarm(goa), .o_mains_volt_alarm(mva), .o_disable_auto_start(das),
    .o_fault_reset(frs), .o_alarm_mute(amt), .o_panel_lock(plk), .o_exercise_active(exa), .o_engine_run_req(rreq),
    .o_gen_load_req(lreq), .o_auto_led(aled), .o_warmup_done(wud), .o_idle(idl), .o_low_speed_prot_en(lsp),
    .o_low_volt_prot_en(lvp), .o_block_heater(htr), .o_fuel_pump(pmp), .o_fill_timeout(fto), .o_relay(rly));

  gsaux_engine_model eng_u (.i_clock(i_clock), .i_rst(i_rst), .i_run_req(rreq), .i_slow(slow), .o_running(run));

  always #50 i_clock = ~i_clock;

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic press(input int k);
    @(posedge i_clock);
    keys[k] <= 1'b1;
    @(posedge i_clock);
    keys[k] <= 1'b0;
    tick(2);
  endtask : press

  task automatic write_slot(input logic [7:0] s, input logic p);
    @(posedge i_clock);
    {swe, sws, swp} <= {1'b1, s, p};
    @(posedge i_clock);
    swe <= 1'b0;
    tick(1);
  endtask : write_slot

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // a run takes about 1500 cycles
  initial
  begin
    repeat (12000) @(posedge i_clock);
    fail_count++;
    finish_test();
  end

  initial
  begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    // slots are not reset, so all are written first
    for (int s = 0; s < 144; s++)
      write_slot(8'(s), 1'b1);
    for (int v = 0; v < 4; v++)
    begin
      @(posedge i_clock);
      din <= {1'b0, 2'(v), 1'b0};
      tick(2);
      chk("limit set", 16'(lset), 16'(ltab[v]));
    end
    $display("test limit sets finished");
    @(posedge i_clock);
    {din, sp, gvf, goc, mvf} <= {4'h0, 1'b1, 3'h6, 3'h1, 3'h4};
    tick(2);
    chk("phase single", 16'({pmask, gva, goa, mva}), 16'h000A);
    @(posedge i_clock);
    sp <= 1'b0;
    tick(2);
    chk("phase all", 16'({pmask, gva, goa, mva}), 16'h003F);
    @(posedge i_clock);
    {gvf, goc, mvf} <= 9'h000;
    $display("test phases finished");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge i_clock);
      {temp, lvl} <= {htab[i], ptab[i]};
      tick(2);
      chk("heater", 16'({htr, rly[1]}), 16'((5'b00110 >> i) & 5'h01) * 16'h0003);
      chk("pump", 16'({pmp, rly[2]}), 16'((5'b10110 >> i) & 5'h01) * 16'h0003);
    end
    $display("test heater finished");
    tick(100);
    chk("fill timeout", 16'({pmp, fto}), 16'h0001);
    @(posedge i_clock);
    {ifn[0], din[0]} <= {FN_FAULT_RESET, 1'b1};
    tick(2);
    chk("timeout cleared", 16'({pmp, fto}), 16'h0002);
    @(posedge i_clock);
    din[0] <= 1'b0;
    tick(2);
    chk("pump restart", 16'(pmp), 16'h0001);
    for (int r = 0; r < 4; r++)
    begin
      @(posedge i_clock);
      for (int j = 0; j < 4; j++)
        rfn[j] <= (j == r) ? RLY_FUEL_PUMP : RLY_NONE;
      tick(2);
      chk("relay route", 16'(rly), 16'h0001 << r);
    end
    @(posedge i_clock);
    {rfn, lvl} <= {RLY_IDLE, RLY_FUEL_PUMP, RLY_BLOCK_HEATER, RLY_NONE, 8'hC8};
    $display("test pump finished");
    press(2);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge i_clock);
      {ifn[0], din[0]} <= {ftab[i], 1'b1};
      tick(2);
      // an ignored stop key must leave no trace
      if (i < 3 || i == 6)
        press(0);
      chk("forced mode", 16'(mode), 16'(mtab[i]));
      chk("functions", 16'({das, frs, amt, plk}), 16'(otab[i]));
      @(posedge i_clock);
      din[0] <= 1'b0;
      tick(2);
      chk("key mode back", 16'(mode), 16'(MODE_RUN));
    end
    $display("test modes finished");
    press(0);
    @(posedge i_clock);
    {dow, dom, hr} <= {3'h2, 5'h09, 5'h04};
    @(posedge i_clock);
    hr <= 5'h05;
    tick(2);
    chk("off-load start", 16'({exa, mode, rreq}), 16'h000D);
    tick(80);
    chk("off-load no load", 16'(lreq), 16'h0000);
    @(posedge i_clock);
    mf <= 1'b1;
    tick(2);
    chk("no backup", 16'(lreq), 16'h0000);
    @(posedge i_clock);
    eb <= 1'b1;
    tick(2);
    chk("backup", 16'(lreq), 16'h0001);
    @(posedge i_clock);
    {mf, eb} <= 2'h0;
    for (int c = 0; c < 2600 && exa !== 1'b0; c++)
      @(posedge i_clock);
    tick(2);
    chk("exercise end", 16'({exa, mode}), 16'(MODE_STOP));
    @(posedge i_clock);
    hr <= 5'h06;
    tick(80);
    chk("on-load run", 16'({exa, mode, lreq}), 16'h000F);
    press(1);
    chk("key ends exercise", 16'({exa, mode}), 16'(MODE_AUTO));
    $display("test exerciser finished");
    @(posedge i_clock);
    mf <= 1'b1;
    tick(4);
    chk("permitted", 16'(rreq), 16'h0001);
    write_slot(8'h36, 1'b0);
    tick(4);
    chk("blocked", 16'(rreq), 16'h0000);
    led = 2'h0;
    repeat (12)
    begin
      tick(1);
      led = led | (2'h1 << aled);
    end
    chk("auto led flash", 16'(led), 16'h0003);
    write_slot(8'h36, 1'b1);
    @(posedge i_clock);
    {mf, wut} <= {1'b0, 16'h0002};
    tick(4);
    $display("test scheduler finished");
    @(posedge i_clock);
    din[3] <= 1'b1;
    tick(20);
    chk("idle on", 16'({idl, rly[3], lsp, lvp, wud}), 16'h0018);
    tick(50);
    chk("idle off", 16'({idl, lsp, lvp, wud}), 16'h0007);
    @(posedge i_clock);
    cool <= 1'b1;
    tick(4);
    chk("cool-down idle", 16'(idl), 16'h0001);
    @(posedge i_clock);
    {cool, din[3]} <= 2'h0;
    tick(4);
    @(posedge i_clock);
    {wum, temp, slow, din[3]} <= {1'b1, 8'h5A, 1'b1, 1'b1};
    tick(20);
    chk("warm skip", 16'(wud), 16'h0001);
    @(posedge i_clock);
    din[3] <= 1'b0;
    tick(4);
    @(posedge i_clock);
    {temp, din[3]} <= {8'h3C, 1'b1};
    tick(80);
    chk("cold waits", 16'(wud), 16'h0000);
    @(posedge i_clock);
    temp <= 8'h55;
    tick(4);
    chk("warm reached", 16'(wud), 16'h0001);
    $display("test warm-up finished");
    finish_test();
  end
endmodule : gsaux_sequencer_bench
